/* File: core/gp_timer_with_capture.sv */
// General-purpose 32-bit up/down timer with event capture, APB slave.
// Assumes an APB master on i_clk, sources synchronous to i_clk.
// How it works
// [R1] Control bit 8 set counts up, clear counts down; down after reset.
// [R2] Control bits 11:9 pick core clock, oscillator or one of two inputs.
// [R3] Control bits 3:0 divide the source by 1, 16, 256 or 32768.
// [R4] Control bits 5:4 pick binary or time-of-day with 23 or 255 hours.
// [R5] First assertion of chosen event copies the count to capture; counting goes on.
// [R6] Capture works only with bit 17 set; bits 16:12 pick the event.
// [R7] Counter reloads from load on overflow or underflow in periodic mode only, and at once on clear write.
// [R8] Any write to the clear register clears the overflow status bit; the capture status bit stays.
// [R9] Counter runs only while control bit 7 is set; clear after reset.
// [R10] Bit 6 set is periodic mode, clear is free-running; free after reset.
// [R11] In low power, oscillator and external sources keep counting.
// [R12] Value register shows the live count; writes to it do nothing.
// [R13] Software writes zeros into reserved control bits 31:18.
// [R14] Overflow or underflow sets status bit 0, raising the interrupt while mask bit 0 is set, until the clear write or a status write of 1 to it.
`timescale 1ns/10ps
module gp_timer_with_capture (
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   // APB slave
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [31:0] i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic             o_pready,
   output logic             o_pslverr,
   output logic [31:0]      o_prdata,
   // Clock sources and power state
   input  wire logic        i_osc_32k,
   input  wire logic        i_ext_clock_input_a,
   input  wire logic        i_ext_clock_input_b,
   input  wire logic        i_low_power,
   // Capture events
   input  wire logic [31:0] i_irq_sources,
   // Interrupt
   output logic             o_irq
);

   // ************************************************************
   // Declarations
   // ************************************************************
   logic [31:0] load_reg;
   logic [31:0] load_next;
   logic [31:0] control_reg;
   logic [31:0] control_next;
   logic [31:0] count_reg;
   logic [31:0] count_next;
   logic [31:0] capture_reg;
   logic [31:0] capture_next;
   logic        event_dly_reg;
   logic        event_dly_next;
   logic [1:0]  status_reg;
   logic [1:0]  status_next;
   logic [1:0]  mask_reg;
   logic [1:0]  mask_next;
   logic        irq_reg;
   logic        irq_next;
   logic        pready_reg;
   logic        pready_next;
   logic        pslverr_reg;
   logic        pslverr_next;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;

   logic        setup_phase;
   logic        wr_access;
   logic        hit_load;
   logic        hit_value;
   logic        hit_control;
   logic        hit_clear;
   logic        hit_capture;
   logic        hit_status;
   logic        hit_mask;
   logic        hit_any;
   logic        clear_wr;
   logic        tick;
   logic        count_up;
   logic        periodic;
   logic [1:0]  fmt;
   logic        hms_mode;
   logic [31:0] step_value;
   logic        wrap;
   logic        sel_event;
   logic        capture_evt;

   // ************************************************************
   // Control field views
   // ************************************************************
   assign count_up = control_reg[gp_timer_pkg::CTL_COUNT_UP];     // R1
   assign periodic = control_reg[gp_timer_pkg::CTL_PERIODIC];     // R10
   assign fmt      = control_reg[gp_timer_pkg::CTL_FORMAT_LSB +: 2];
   assign hms_mode = (fmt == gp_timer_pkg::FMT_HMS23) ||
                     (fmt == gp_timer_pkg::FMT_HMS255);           // R4

   // ************************************************************
   // APB address decode
   // ************************************************************
   always_comb begin
      setup_phase = i_psel && !i_penable;
      wr_access   = i_psel && i_penable && pready_reg && i_pwrite;
      hit_load    = (i_paddr == gp_timer_pkg::ADDR_LOAD);
      hit_value   = (i_paddr == gp_timer_pkg::ADDR_VALUE);
      hit_control = (i_paddr == gp_timer_pkg::ADDR_CONTROL);
      hit_clear   = (i_paddr == gp_timer_pkg::ADDR_CLEAR);
      hit_capture = (i_paddr == gp_timer_pkg::ADDR_CAPTURE);
      hit_status  = (i_paddr == gp_timer_pkg::ADDR_STATUS);
      hit_mask    = (i_paddr == gp_timer_pkg::ADDR_MASK);
      hit_any     = hit_load || hit_value || hit_control || hit_clear ||
                    hit_capture || hit_status || hit_mask;
      clear_wr    = wr_access && hit_clear;                       // R8
   end

   // ************************************************************
   // APB answer: one access cycle, no wait states
   // ************************************************************
   always_comb begin
      pready_next  = setup_phase;
      pslverr_next = setup_phase && !hit_any;
      prdata_next  = 32'h00000000;
      if (setup_phase && !i_pwrite) begin
         unique case (1'b1)
            hit_load:    prdata_next = load_reg;
            hit_value:   prdata_next = count_reg;                 // R12
            hit_control: prdata_next = control_reg;
            hit_capture: prdata_next = capture_reg;
            hit_status:  prdata_next = {30'h0, status_reg};
            hit_mask:    prdata_next = {30'h0, mask_reg};
            default:     prdata_next = 32'h00000000;
         endcase
      end
   end

   // ************************************************************
   // Software-written registers
   // ************************************************************
   always_comb begin
      load_next    = load_reg;
      control_next = control_reg;
      mask_next    = mask_reg;
      if (wr_access && hit_load) begin
         load_next = i_pwdata;
      end
      if (wr_access && hit_control) begin
         control_next = i_pwdata & gp_timer_pkg::CTL_WRITABLE;    // R13
      end
      if (wr_access && hit_mask) begin
         mask_next = i_pwdata[1:0];
      end
   end

   // ************************************************************
   // Tick source and prescaler
   // ************************************************************
   timer_tick_gen u_tick_gen (
      .i_clk               (i_clk),
      .i_rst_n             (i_rst_n),
      .i_clk_sel           (control_reg[gp_timer_pkg::CTL_CLKSEL_LSB +: 3]),
      .i_prescale          (control_reg[gp_timer_pkg::CTL_PRESCALE_LSB +: 4]),
      .i_low_power         (i_low_power),
      .i_restart           (clear_wr),
      .i_osc_32k           (i_osc_32k),
      .i_ext_clock_input_a (i_ext_clock_input_a),
      .i_ext_clock_input_b (i_ext_clock_input_b),
      .o_tick              (tick)
   );

   // ************************************************************
   // One count step in the selected format
   // ************************************************************
   always_comb begin : step_calc
      logic [7:0] lim;
      logic [7:0] fld;
      logic       carry;
      lim   = 8'h00;
      fld   = 8'h00;
      carry = 1'b1;
      step_value = count_reg;
      if (!hms_mode) begin
         if (count_up) begin
            step_value = count_reg + 32'h00000001;               // R1
            carry      = (count_reg == 32'hffffffff);
         end else begin
            step_value = count_reg - 32'h00000001;               // R1
            carry      = (count_reg == 32'h00000000);
         end
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (i == 0) begin
               lim = gp_timer_pkg::LIM_HUNDREDTHS;
            end else if (i < 3) begin
               lim = gp_timer_pkg::LIM_MINSEC;
            end else if (fmt == gp_timer_pkg::FMT_HMS23) begin
               lim = gp_timer_pkg::LIM_HOURS23;                   // R4
            end else begin
               lim = gp_timer_pkg::LIM_HOURS255;                  // R4
            end
            fld = count_reg[8*i +: 8];
            if (carry) begin
               if (count_up) begin
                  if (fld >= lim) begin
                     fld = 8'h00;
                  end else begin
                     fld   = fld + 8'h01;
                     carry = 1'b0;
                  end
               end else begin
                  if (fld == 8'h00) begin
                     fld = lim;
                  end else begin
                     fld   = fld - 8'h01;
                     carry = 1'b0;
                  end
               end
            end
            step_value[8*i +: 8] = fld;
         end
      end
      wrap = carry;
   end

   // ************************************************************
   // Counter: hold, step, wrap or reload
   // ************************************************************
   always_comb begin
      count_next = count_reg;
      if (clear_wr) begin
         count_next = load_reg;                                   // R7
      end else if (control_reg[gp_timer_pkg::CTL_ENABLE] && tick) begin // R9 R11
         if (wrap && periodic) begin
            count_next = load_reg;                                // R7 R10
         end else begin
            count_next = step_value;                              // R10
         end
      end
   end

   // ************************************************************
   // Event capture on first assertion of the chosen source
   // ************************************************************
   always_comb begin
      sel_event      = i_irq_sources[control_reg[gp_timer_pkg::CTL_EVSEL_LSB +: 5]]; // R6
      event_dly_next = sel_event;
      capture_evt    = control_reg[gp_timer_pkg::CTL_CAPTURE_EN] &&
                       sel_event && !event_dly_reg;               // R5 R6
      capture_next   = capture_reg;
      if (capture_evt) begin
         capture_next = count_reg;                                // R5
      end
   end

   // ************************************************************
   // Sticky status, mask and interrupt line
   // ************************************************************
   always_comb begin
      status_next = status_reg;
      if (wr_access && hit_status) begin
         status_next = status_reg & ~i_pwdata[1:0];
      end
      if (clear_wr) begin
         status_next[gp_timer_pkg::ST_WRAP] = 1'b0;              // R8
      end
      if (control_reg[gp_timer_pkg::CTL_ENABLE] && tick && wrap && !clear_wr) begin
         status_next[gp_timer_pkg::ST_WRAP] = 1'b1;              // R14
      end
      if (capture_evt) begin
         status_next[gp_timer_pkg::ST_CAPTURE] = 1'b1;
      end
      irq_next = |(status_next & mask_next);                     // R14
   end

   // ************************************************************
   // Registers
   // ************************************************************
   // APB answer
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h00000000;
      end else begin
         pready_reg  <= pready_next;
         pslverr_reg <= pslverr_next;
         prdata_reg  <= prdata_next;
      end
   end

   // Software-written registers
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         load_reg    <= gp_timer_pkg::RST_LOAD;
         control_reg <= gp_timer_pkg::RST_CONTROL;
         mask_reg    <= gp_timer_pkg::RST_MASK;
      end else begin
         load_reg    <= load_next;
         control_reg <= control_next;
         mask_reg    <= mask_next;
      end
   end

   // Counter
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         count_reg <= gp_timer_pkg::RST_VALUE;
      end else begin
         count_reg <= count_next;
      end
   end

   // Capture and event edge detector
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         capture_reg   <= gp_timer_pkg::RST_CAPTURE;
         event_dly_reg <= 1'b0;
      end else begin
         capture_reg   <= capture_next;
         event_dly_reg <= event_dly_next;
      end
   end

   // Status and interrupt line
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         status_reg <= gp_timer_pkg::RST_STATUS;
         irq_reg    <= 1'b0;
      end else begin
         status_reg <= status_next;
         irq_reg    <= irq_next;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign o_pready  = pready_reg;
   assign o_pslverr = pslverr_reg;
   assign o_prdata  = prdata_reg;
   assign o_irq     = irq_reg;

endmodule // gp_timer_with_capture

/* File: core/gp_timer_pkg.sv */
// Constants for the general-purpose timer with event capture.
// Assumes a 32-bit APB register bus and a 125 MHz core clock.
package gp_timer_pkg;

   // ************************************************************
   // Register byte addresses
   // ************************************************************
   localparam logic [31:0] ADDR_LOAD    = 32'hffff0380;
   localparam logic [31:0] ADDR_VALUE   = 32'hffff0384;
   localparam logic [31:0] ADDR_CONTROL = 32'hffff0388;
   localparam logic [31:0] ADDR_CLEAR   = 32'hffff038c;
   localparam logic [31:0] ADDR_CAPTURE = 32'hffff0390;
   localparam logic [31:0] ADDR_STATUS  = 32'hffff0394;
   localparam logic [31:0] ADDR_MASK    = 32'hffff0398;

   // ************************************************************
   // Values after reset
   // ************************************************************
   localparam logic [31:0] RST_LOAD     = 32'h00000000;
   localparam logic [31:0] RST_VALUE    = 32'h00000000;
   localparam logic [31:0] RST_CONTROL  = 32'h00000000;
   localparam logic [31:0] RST_CAPTURE  = 32'h00000000;
   localparam logic [1:0]  RST_STATUS   = 2'h0;
   localparam logic [1:0]  RST_MASK     = 2'h3;

   // ************************************************************
   // Control field positions
   // ************************************************************
   localparam int CTL_PRESCALE_LSB = 0;
   localparam int CTL_FORMAT_LSB   = 4;
   localparam int CTL_PERIODIC     = 6;
   localparam int CTL_ENABLE       = 7;
   localparam int CTL_COUNT_UP     = 8;
   localparam int CTL_CLKSEL_LSB   = 9;
   localparam int CTL_EVSEL_LSB    = 12;
   localparam int CTL_CAPTURE_EN   = 17;
   localparam logic [31:0] CTL_WRITABLE = 32'h0003ffff;

   // ************************************************************
   // Field encodings
   // ************************************************************
   localparam logic [2:0] CLK_CORE  = 3'h0;
   localparam logic [2:0] CLK_OSC   = 3'h1;
   localparam logic [2:0] CLK_EXT_A = 3'h2;
   localparam logic [2:0] CLK_EXT_B = 3'h3;
   localparam logic [3:0] DIV_1     = 4'h0;
   localparam logic [3:0] DIV_16    = 4'h4;
   localparam logic [3:0] DIV_256   = 4'h8;
   localparam logic [3:0] DIV_32768 = 4'hf;
   localparam logic [1:0] FMT_HMS23  = 2'h2;
   localparam logic [1:0] FMT_HMS255 = 2'h3;

   // ************************************************************
   // Time-of-day field limits and status bits
   // ************************************************************
   localparam logic [7:0] LIM_HUNDREDTHS = 8'h63;
   localparam logic [7:0] LIM_MINSEC     = 8'h3b;
   localparam logic [7:0] LIM_HOURS23    = 8'h17;
   localparam logic [7:0] LIM_HOURS255   = 8'hff;
   localparam int ST_WRAP    = 0;
   localparam int ST_CAPTURE = 1;

endpackage

/* File: core/timer_tick_gen.sv */
// Count tick generator: source select, edge detect and prescaler.
// Assumes all source inputs are synchronous to i_clk.
`timescale 1ns/10ps
module timer_tick_gen (
   // Clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   // Configuration
   input  wire logic [2:0] i_clk_sel,
   input  wire logic [3:0] i_prescale,
   input  wire logic       i_low_power,
   input  wire logic       i_restart,
   // Clock sources
   input  wire logic       i_osc_32k,
   input  wire logic       i_ext_clock_input_a,
   input  wire logic       i_ext_clock_input_b,
   // Tick out
   output logic            o_tick
);

   logic [2:0]  src_dly_reg;
   logic [2:0]  src_dly_next;
   logic [14:0] div_reg;
   logic [14:0] div_next;
   logic        tick_reg;
   logic        tick_next;
   logic        src_edge;
   logic [14:0] div_top;

   // ************************************************************
   // Source edge and divider
   // ************************************************************
   always_comb begin
      src_dly_next = {i_ext_clock_input_b, i_ext_clock_input_a, i_osc_32k};
      unique case (i_clk_sel)
         gp_timer_pkg::CLK_CORE:  src_edge = !i_low_power;                          // R2 R11
         gp_timer_pkg::CLK_OSC:   src_edge = i_osc_32k && !src_dly_reg[0];          // R2 R11
         gp_timer_pkg::CLK_EXT_A: src_edge = i_ext_clock_input_a && !src_dly_reg[1]; // R2
         gp_timer_pkg::CLK_EXT_B: src_edge = i_ext_clock_input_b && !src_dly_reg[2]; // R2
         default:                 src_edge = 1'b0;
      endcase
      unique case (i_prescale)
         gp_timer_pkg::DIV_16:    div_top = 15'h000f;  // R3
         gp_timer_pkg::DIV_256:   div_top = 15'h00ff;  // R3
         gp_timer_pkg::DIV_32768: div_top = 15'h7fff;  // R3
         default:                 div_top = 15'h0000;  // R3
      endcase
      div_next  = div_reg;
      tick_next = 1'b0;
      if (i_restart) begin
         div_next = 15'h0000;
      end else if (src_edge) begin
         if (div_reg >= div_top) begin
            div_next  = 15'h0000;
            tick_next = 1'b1;
         end else begin
            div_next = div_reg + 15'h0001;
         end
      end
   end

   // Registers
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         src_dly_reg <= 3'h0;
         div_reg     <= 15'h0000;
         tick_reg    <= 1'b0;
      end else begin
         src_dly_reg <= src_dly_next;
         div_reg     <= div_next;
         tick_reg    <= tick_next;
      end
   end

   assign o_tick = tick_reg;

endmodule // timer_tick_gen

/* File: test/gp_timer_asserts.sv */
// Checker for the timer's APB slave port.
// Assumes binding onto gp_timer_with_capture; sees its ports only.
`timescale 1ns/10ps
module gp_timer_asserts (
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   // APB
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [31:0] i_paddr,
   input  wire logic        o_pready,
   input  wire logic        o_pslverr,
   input  wire logic [31:0] o_prdata,
   // Interrupt
   input  wire logic        o_irq
);
   // ************************************************************
   // Helpers
   // ************************************************************
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);

   // Setup phase and decoded map
   logic setup;
   logic mapped;
   assign setup  = i_psel && !i_penable;
   assign mapped = (i_paddr >= gp_timer_pkg::ADDR_LOAD) && (i_paddr <= gp_timer_pkg::ADDR_MASK)
                   && (i_paddr[1:0] == 2'h0);

   // ************************************************************
   // Assertions and covers
   // ************************************************************
   AST_READY_AFTER_SETUP: assert property (setup |=> o_pready)
      else $error("pready missing after setup");
   AST_READY_ONE_CYCLE: assert property (o_pready |=> !o_pready)
      else $error("pready held too long");
   AST_READY_CAUSE: assert property (o_pready |-> $past(setup))
      else $error("pready without setup");
   AST_ERR_WITH_READY: assert property (o_pslverr |-> o_pready)
      else $error("pslverr without pready");
   AST_UNMAPPED_ERR: assert property (setup && !mapped |=> o_pslverr)
      else $error("unmapped access not refused");
   AST_MAPPED_OK: assert property (setup && mapped |=> !o_pslverr)
      else $error("mapped access refused");
   AST_CLEAR_READS_ZERO: assert property (
      setup && !i_pwrite && i_paddr == gp_timer_pkg::ADDR_CLEAR |=> o_prdata == 32'h0)
      else $error("clear register readable");
   AST_CTL_RESERVED_ZERO: assert property (
      setup && !i_pwrite && i_paddr == gp_timer_pkg::ADDR_CONTROL |=> o_prdata[31:18] == 14'h0)
      else $error("reserved control bits not zero");
   AST_WRITE_NO_DATA: assert property (setup && i_pwrite |=> o_prdata == 32'h0)
      else $error("read data on write");

   // Main scenarios reached
   cover property (setup && !mapped);
   cover property ($rose(o_irq));
   cover property ($fell(o_irq));
endmodule // gp_timer_asserts

/* File: test/gp_timer_with_capture_tb_top.sv */
// Self-checking bench for the APB timer with event capture.
// Assumes the design, its package and the checker are compiled first.
`timescale 1ns/10ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
   $display("ERROR %0t: got %h expected %h", $time, (g), (e)); end end
module gp_timer_with_capture_tb_top;
   // ************************************************************
   // Addresses and signals
   // ************************************************************
   localparam logic [31:0] LD = gp_timer_pkg::ADDR_LOAD;
   localparam logic [31:0] VL = gp_timer_pkg::ADDR_VALUE;
   localparam logic [31:0] CT = gp_timer_pkg::ADDR_CONTROL;
   localparam logic [31:0] CL = gp_timer_pkg::ADDR_CLEAR;
   localparam logic [31:0] CP = gp_timer_pkg::ADDR_CAPTURE;
   localparam logic [31:0] ST = gp_timer_pkg::ADDR_STATUS;
   localparam logic [31:0] MK = gp_timer_pkg::ADDR_MASK;
   logic        i_clk, i_rst_n, i_psel, i_penable, i_pwrite, o_pready, o_pslverr, o_irq;
   logic [31:0] i_paddr, i_pwdata, o_prdata, i_irq_sources, rdat;
   logic        i_osc_32k, i_ext_clock_input_a, i_ext_clock_input_b, i_low_power, rerr;
   int          n_errors = 0;
   int          samples_checked = 0;
   int          cyc = 0;

   // Device under test
   gp_timer_with_capture dut (
      .i_clk, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
      .o_pready, .o_pslverr, .o_prdata, .i_osc_32k, .i_ext_clock_input_a,
      .i_ext_clock_input_b, .i_low_power, .i_irq_sources, .o_irq
   );

   // ************************************************************
   // Tasks
   // ************************************************************
   // One APB transfer, waits for pready
   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      i_psel <= 1'b1;
      i_pwrite <= wr;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_clk);
      i_penable <= 1'b1;
      @(posedge i_clk);
      while (o_pready !== 1'b1) @(posedge i_clk);
      rdat = o_prdata;
      rerr = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      @(posedge i_clk);
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      `CHK(rerr, 1'b0)
   endtask

   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(rdat, e)
   endtask

   // Load and reload at once through the clear register
   task automatic ld(input logic [31:0] d);
      wr(LD, d);
      wr(CL, 32'h0);
   endtask

   // Pulses on the sources: bit 0 oscillator, 1 input a, 2 input b
   task automatic pulse(input logic [2:0] m, input int k);
      repeat (k) begin
         {i_ext_clock_input_b, i_ext_clock_input_a, i_osc_32k} <= m;
         repeat (2) @(posedge i_clk);
         {i_ext_clock_input_b, i_ext_clock_input_a, i_osc_32k} <= 3'h0;
         repeat (2) @(posedge i_clk);
      end
      repeat (2) @(posedge i_clk);
   endtask

   task automatic irq_is(input logic e);
      repeat (2) @(posedge i_clk);
      `CHK(o_irq, e)
   endtask

   task automatic final_report();
      if (n_errors == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ************************************************************
   // Clock, timeout and sequence
   // ************************************************************
   // Free-running 125 MHz clock
   initial begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end

   // Hang guard
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         n_errors++;
         $display("ERROR %0t: timeout", $time);
         final_report();
      end
   end

   // Main test sequence
   initial begin
      i_rst_n = 1'b0;
      {i_psel, i_penable, i_pwrite, i_low_power} = 4'h0;
      {i_osc_32k, i_ext_clock_input_a, i_ext_clock_input_b} = 3'h0;
      {i_paddr, i_pwdata, i_irq_sources} = '0;
      repeat (6) @(posedge i_clk);
      i_rst_n <= 1'b1;
      @(posedge i_clk);
      rd(LD, 32'h0);
      rd(VL, 32'h0);
      rd(CT, 32'h0);
      rd(CP, 32'h0);
      rd(MK, 32'h3);
      rd(ST, 32'h0);
      rd(CL, 32'h0);
      apb(1'b0, 32'hffff039c, 32'h0);
      `CHK(rerr, 1'b1)
      wr(VL, 32'h1234);
      rd(VL, 32'h0);
      wr(CT, 32'h0003ffff);
      rd(CT, 32'h0003ffff);
      ld(32'h10);
      rd(VL, 32'h10);
      wr(CT, 32'h280);
      pulse(3'h1, 1);
      rd(VL, 32'hf);
      pulse(3'h2, 1);
      rd(VL, 32'hf);
      wr(CT, 32'h480);
      pulse(3'h2, 1);
      rd(VL, 32'he);
      wr(CT, 32'h680);
      pulse(3'h2, 1);
      pulse(3'h4, 1);
      rd(VL, 32'hd);
      wr(CT, 32'h380);
      pulse(3'h1, 2);
      rd(VL, 32'hf);
      wr(CT, 32'h200);
      pulse(3'h1, 1);
      rd(VL, 32'hf);
      // Low power: core source halts, oscillator keeps going
      i_low_power <= 1'b1;
      wr(CT, 32'h80);
      rd(VL, 32'hf);
      wr(CT, 32'h280);
      pulse(3'h1, 1);
      rd(VL, 32'he);
      i_low_power <= 1'b0;
      // Divide by 16 and by 256, one short of the step then the step
      for (int i = 0; i < 2; i++) begin
         wr(CT, 32'h284 + 32'(i * 4));
         ld(32'h10);
         pulse(3'h1, (16 << (4 * i)) - 1);
         rd(VL, 32'h10);
         pulse(3'h1, 1);
         rd(VL, 32'hf);
      end
      // Core clock divided by 32768, just short of the step then past it
      wr(CT, 32'h8f);
      ld(32'h10);
      repeat (32700) @(posedge i_clk);
      rd(VL, 32'h10);
      repeat (100) @(posedge i_clk);
      rd(VL, 32'hf);
      // Underflow, interrupt, mask, clear, periodic reload
      ld(32'h1);
      wr(CT, 32'h280);
      pulse(3'h1, 2);
      rd(VL, 32'hffffffff);
      irq_is(1'b1);
      rd(ST, 32'h1);
      wr(MK, 32'h0);
      irq_is(1'b0);
      wr(MK, 32'h3);
      irq_is(1'b1);
      wr(CL, 32'h5a);
      irq_is(1'b0);
      rd(VL, 32'h1);
      wr(CT, 32'h2c0);
      pulse(3'h1, 2);
      rd(VL, 32'h1);
      irq_is(1'b1);
      wr(ST, 32'h1);
      irq_is(1'b0);
      // Time-of-day wraps and carries
      wr(CT, 32'h2a0);
      ld(32'h0);
      pulse(3'h1, 1);
      rd(VL, 32'h173b3b63);
      wr(CT, 32'h2b0);
      ld(32'h0);
      pulse(3'h1, 1);
      rd(VL, 32'hff3b3b63);
      wr(CT, 32'h3a0);
      ld(32'h00003b63);
      pulse(3'h1, 1);
      rd(VL, 32'h00010000);
      ld(32'h173b3b63);
      pulse(3'h1, 1);
      rd(VL, 32'h0);
      // Capture on event line 5
      wr(ST, 32'h3);
      wr(CT, 32'h25280);
      ld(32'h55);
      i_irq_sources <= 32'h20;
      irq_is(1'b1);
      rd(CP, 32'h55);
      rd(ST, 32'h2);
      pulse(3'h1, 1);
      rd(VL, 32'h54);
      i_irq_sources <= 32'h10;
      rd(CP, 32'h55);
      wr(CT, 32'h05280);
      i_irq_sources <= 32'h20;
      rd(CP, 32'h55);
      wr(CT, 32'h25280);
      i_irq_sources <= 32'h0;
      irq_is(1'b1);
      i_irq_sources <= 32'h20;
      irq_is(1'b1);
      rd(CP, 32'h54);
      final_report();
   end
endmodule // gp_timer_with_capture_tb_top

// Checker beside the top module's ports
bind gp_timer_with_capture gp_timer_asserts u_chk (
   .i_clk, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr,
   .o_pready, .o_pslverr, .o_prdata, .o_irq
);
